/* File: verilog/hb_fault_pkg.sv */
`default_nettype none

package hb_fault_pkg;

  localparam int NUM_BRIDGES = 12;
  localparam int CNT_W = 20;
  localparam int CLK_PERIOD_NS = 10;

  // On-state open-load filter time and its cycle count at the core clock.
  localparam int OL_FILTER_TIME_MS = 3;
  localparam logic [CNT_W-1:0] OL_FILTER_CYCLES = CNT_W'(OL_FILTER_TIME_MS * 1000000 / CLK_PERIOD_NS);

  // Low-threshold open-load filter time; no figure is given, so this is a plain default.
  localparam int OL_LOW_FILTER_TIME_US = 500;
  localparam logic [CNT_W-1:0] OL_LOW_FILTER_CYCLES = CNT_W'(OL_LOW_FILTER_TIME_US * 1000 / CLK_PERIOD_NS);

  // Overcurrent filter times, long (default) and short; plain defaults.
  localparam int OVERCURRENT_FILTER_SELECT_LONG_NS = 10000;
  localparam int OVERCURRENT_FILTER_SELECT_SHORT_NS = 5000;

  localparam logic [NUM_BRIDGES-1:0] FLAGS_RESET = 12'h000;

  // Analog sense group carried together through the pin synchroniser.
  typedef struct packed {
    logic fault_line;
    logic [NUM_BRIDGES-1:0] sd;
    logic [NUM_BRIDGES-1:0] warn;
    logic [NUM_BRIDGES-1:0] level;
    logic [NUM_BRIDGES-1:0] ls_ul_low;
    logic [NUM_BRIDGES-1:0] ls_ul;
    logic [NUM_BRIDGES-1:0] hs_ul;
    logic [NUM_BRIDGES-1:0] ls_oc;
    logic [NUM_BRIDGES-1:0] hs_oc;
  } sense_t;

  localparam int SENSE_W = $bits(sense_t);

endpackage : hb_fault_pkg

`default_nettype wire

/* File: verilog/pin_sync3.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] stable_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] stable_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit is accepted only once the second and third stages agree.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stable_q <= '0;
    end else begin
      stable_q <= (s2_q & ~(s2_q ^ s3_q)) | (stable_q & (s2_q ^ s3_q));
    end
  end

  assign stable_out = stable_q;

endmodule : pin_sync3

`default_nettype wire

/* File: verilog/fault_filter.sv */
`timescale 1ns/100ps
`default_nettype none

module fault_filter #(
  parameter int CW = 20
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cond_in,
  input wire logic [CW-1:0] limit_in,
  output logic confirmed_out
);

  logic [CW-1:0] cnt_q;

  // Any gap in the condition restarts the filter from zero.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else if (!cond_in) begin
      cnt_q <= '0;
    end else if (cnt_q < limit_in) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign confirmed_out = cond_in && (cnt_q >= limit_in);

endmodule : fault_filter

`default_nettype wire

/* File: verilog/hb_fault_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none

module hb_fault_supervisor
  import hb_fault_pkg::*;
#(
  parameter logic [CNT_W-1:0] OL_CYCLES = OL_FILTER_CYCLES,
  parameter logic [CNT_W-1:0] OL_LOW_CYCLES = OL_LOW_FILTER_CYCLES,
  parameter int OC_LONG_NS = OVERCURRENT_FILTER_SELECT_LONG_NS,
  parameter int OC_SHORT_NS = OVERCURRENT_FILTER_SELECT_SHORT_NS
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic [NUM_BRIDGES-1:0] HIGH_SIDE_ENABLE_IN,
  input wire logic [NUM_BRIDGES-1:0] LOW_SIDE_ENABLE_IN,
  input wire logic [NUM_BRIDGES-1:0] BRIDGE_PWM_DRIVE_MODE_IN,
  input wire logic [NUM_BRIDGES-1:0] PWM_PHASE_ON_IN,
  input wire logic OVERCURRENT_ALERT_MASK_IN,
  input wire logic READ_CLEARS_FLAGS_IN,
  input wire logic STATUS_READ_IN,
  input wire logic CLEAR_FAULT_COMMAND_IN,
  input wire logic OVERCURRENT_TURNOFF_SLOW_IN,
  input wire logic OVERCURRENT_FILTER_SELECT_IN,
  input wire logic [NUM_BRIDGES-1:0] LOW_OPENLOAD_THRESHOLD_SELECT_IN,
  input wire logic OPENLOAD_FLAG_ONLY_IN,
  input wire logic OPENLOAD_ALERT_MASK_IN,
  input wire logic [NUM_BRIDGES-1:0] OPENLOAD_DETECT_DISABLE_IN,
  input wire logic THERMAL_WARNING_ALERT_ENABLE_IN,
  input wire logic [NUM_BRIDGES-1:0] PULLUP_ENABLE_IN,
  input wire logic [NUM_BRIDGES-1:0] PULLDOWN_ENABLE_IN,
  input wire logic [NUM_BRIDGES-1:0] HS_OVERCURRENT_IN,
  input wire logic [NUM_BRIDGES-1:0] LS_OVERCURRENT_IN,
  input wire logic [NUM_BRIDGES-1:0] HS_UNDERLOAD_IN,
  input wire logic [NUM_BRIDGES-1:0] LS_UNDERLOAD_IN,
  input wire logic [NUM_BRIDGES-1:0] LS_UNDERLOAD_LOW_IN,
  input wire logic [NUM_BRIDGES-1:0] OFFSTATE_COMPARE_IN,
  input wire logic [NUM_BRIDGES-1:0] THERMAL_WARNING_IN,
  input wire logic [NUM_BRIDGES-1:0] THERMAL_SHUTDOWN_IN,
  input wire logic FAULT_ALERT_N_IN,
  output logic FAULT_ALERT_N_OUT,
  output logic FAULT_ALERT_N_OE_N_OUT,
  output logic FAULT_LINE_LEVEL_OUT,
  output logic [NUM_BRIDGES-1:0] HS_GATE_OUT,
  output logic [NUM_BRIDGES-1:0] LS_GATE_OUT,
  output logic [NUM_BRIDGES-1:0] OC_SLOW_SLEW_OUT,
  output logic [NUM_BRIDGES-1:0] LS_LOW_OC_THRESHOLD_OUT,
  output logic [NUM_BRIDGES-1:0] PULLUP_OUT,
  output logic [NUM_BRIDGES-1:0] PULLDOWN_OUT,
  output logic [NUM_BRIDGES-1:0] HIGH_SIDE_OVERCURRENT_FLAG_OUT,
  output logic [NUM_BRIDGES-1:0] LOW_SIDE_OVERCURRENT_FLAG_OUT,
  output logic [NUM_BRIDGES-1:0] HS_OPENLOAD_FLAG_OUT,
  output logic [NUM_BRIDGES-1:0] LS_OPENLOAD_FLAG_OUT,
  output logic [NUM_BRIDGES-1:0] OFFSTATE_COMPARE_LEVEL_OUT,
  output logic THERMAL_WARNING_OUT,
  output logic [NUM_BRIDGES-1:0] THERMAL_SHUTDOWN_OUT
);

  localparam logic [CNT_W-1:0] OC_LONG_CYC = CNT_W'(OC_LONG_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OC_SHORT_CYC = CNT_W'(OC_SHORT_NS / CLK_PERIOD_NS);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation of the analog comparator outputs.

  sense_t sense_raw;
  sense_t sense;
  logic [SENSE_W-1:0] sense_bits;

  always_comb begin
    sense_raw.fault_line = FAULT_ALERT_N_IN;
    sense_raw.sd = THERMAL_SHUTDOWN_IN;
    sense_raw.warn = THERMAL_WARNING_IN;
    sense_raw.level = OFFSTATE_COMPARE_IN;
    sense_raw.ls_ul_low = LS_UNDERLOAD_LOW_IN;
    sense_raw.ls_ul = LS_UNDERLOAD_IN;
    sense_raw.hs_ul = HS_UNDERLOAD_IN;
    sense_raw.ls_oc = LS_OVERCURRENT_IN;
    sense_raw.hs_oc = HS_OVERCURRENT_IN;
  end

  pin_sync3 #(
    .W(SENSE_W)
  ) u_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .async_in(sense_raw),
    .stable_out(sense_bits)
  );

  assign sense = sense_t'(sense_bits);

  //////////////////////////////////////////////////////////////////////////////
  // Drive request and shutdown terms.

  logic clear_req;
  logic [NUM_BRIDGES-1:0] hs_oc_q;
  logic [NUM_BRIDGES-1:0] ls_oc_q;
  logic [NUM_BRIDGES-1:0] hs_ol_q;
  logic [NUM_BRIDGES-1:0] ls_ol_q;
  logic [NUM_BRIDGES-1:0] sd_flag_q;
  logic warn_flag_q;
  logic [NUM_BRIDGES-1:0] drive_hs;
  logic [NUM_BRIDGES-1:0] drive_ls;
  logic [NUM_BRIDGES-1:0] oc_off;
  logic [NUM_BRIDGES-1:0] bridge_off;
  logic [NUM_BRIDGES-1:0] hs_oc_conf;
  logic [NUM_BRIDGES-1:0] ls_oc_conf;
  logic [NUM_BRIDGES-1:0] hs_ol_cond;
  logic [NUM_BRIDGES-1:0] ls_ol_cond;
  logic [NUM_BRIDGES-1:0] hs_ol_conf;
  logic [NUM_BRIDGES-1:0] ls_ol_conf;
  logic [NUM_BRIDGES-1:0] hs_gate_q;
  logic [NUM_BRIDGES-1:0] ls_gate_q;
  logic [NUM_BRIDGES-1:0] slow_slew_q;
  logic [NUM_BRIDGES-1:0] low_oc_th_q;
  logic [NUM_BRIDGES-1:0] pullup_q;
  logic [NUM_BRIDGES-1:0] pulldown_q;
  logic [NUM_BRIDGES-1:0] level_q;
  logic alert_oe_n_q;
  logic alert_d;

  assign clear_req = CLEAR_FAULT_COMMAND_IN | (STATUS_READ_IN & READ_CLEARS_FLAGS_IN);

  // Both enables high leaves the bridge floating; in PWM mode the driving
  // side only conducts during the on phase.
  assign drive_hs = HIGH_SIDE_ENABLE_IN & ~LOW_SIDE_ENABLE_IN & (~BRIDGE_PWM_DRIVE_MODE_IN | PWM_PHASE_ON_IN);
  assign drive_ls = LOW_SIDE_ENABLE_IN & ~HIGH_SIDE_ENABLE_IN & (~BRIDGE_PWM_DRIVE_MODE_IN | PWM_PHASE_ON_IN);

  // The latched flag, not the live comparator, holds the bridge off, so a
  // bridge cannot restart on its own after the short disappears.
  assign oc_off = hs_oc_q | ls_oc_q;
  assign bridge_off = oc_off | ((hs_ol_q | ls_ol_q) & {NUM_BRIDGES{~OPENLOAD_FLAG_ONLY_IN}})
                      | sense.sd;

  // Detection only while the stage really conducts.
  assign hs_ol_cond = drive_hs & ~bridge_off & ~OPENLOAD_DETECT_DISABLE_IN & sense.hs_ul;
  assign ls_ol_cond = drive_ls & ~bridge_off & ~OPENLOAD_DETECT_DISABLE_IN
                      & ((LOW_OPENLOAD_THRESHOLD_SELECT_IN & sense.ls_ul_low)
                      | (~LOW_OPENLOAD_THRESHOLD_SELECT_IN & sense.ls_ul));

  //////////////////////////////////////////////////////////////////////////////
  // Per-bridge filters.

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BRIDGES; gi++) begin : g_bridge
      logic [CNT_W-1:0] oc_limit;
      logic [CNT_W-1:0] ls_ol_limit;

      assign oc_limit = OVERCURRENT_FILTER_SELECT_IN ? OC_SHORT_CYC : OC_LONG_CYC;
      assign ls_ol_limit = LOW_OPENLOAD_THRESHOLD_SELECT_IN[gi] ? OL_LOW_CYCLES : OL_CYCLES;

      fault_filter #(.CW(CNT_W)) u_hs_oc (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .cond_in(sense.hs_oc[gi]),
        .limit_in(oc_limit),
        .confirmed_out(hs_oc_conf[gi])
      );

      fault_filter #(.CW(CNT_W)) u_ls_oc (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .cond_in(sense.ls_oc[gi]),
        .limit_in(oc_limit),
        .confirmed_out(ls_oc_conf[gi])
      );

      fault_filter #(.CW(CNT_W)) u_hs_ol (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .cond_in(hs_ol_cond[gi]),
        .limit_in(OL_CYCLES),
        .confirmed_out(hs_ol_conf[gi])
      );

      fault_filter #(.CW(CNT_W)) u_ls_ol (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .cond_in(ls_ol_cond[gi]),
        .limit_in(ls_ol_limit),
        .confirmed_out(ls_ol_conf[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Latched status flags; a new event beats a clear in the same cycle.

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hs_oc_q <= FLAGS_RESET;
      ls_oc_q <= FLAGS_RESET;
    end else begin
      hs_oc_q <= hs_oc_conf | (hs_oc_q & {NUM_BRIDGES{~clear_req}});
      ls_oc_q <= ls_oc_conf | (ls_oc_q & {NUM_BRIDGES{~clear_req}});
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hs_ol_q <= FLAGS_RESET;
      ls_ol_q <= FLAGS_RESET;
    end else begin
      hs_ol_q <= hs_ol_conf | (hs_ol_q & {NUM_BRIDGES{~clear_req}});
      ls_ol_q <= ls_ol_conf | (ls_ol_q & {NUM_BRIDGES{~clear_req}});
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sd_flag_q <= FLAGS_RESET;
      warn_flag_q <= 1'b0;
    end else begin
      sd_flag_q <= sense.sd | (sd_flag_q & {NUM_BRIDGES{~clear_req}});
      warn_flag_q <= (|sense.warn) | (warn_flag_q & ~clear_req);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output stage control. Enables are only read, never written here.

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hs_gate_q <= FLAGS_RESET;
      ls_gate_q <= FLAGS_RESET;
      slow_slew_q <= FLAGS_RESET;
      low_oc_th_q <= FLAGS_RESET;
    end else begin
      hs_gate_q <= drive_hs & ~bridge_off;
      ls_gate_q <= drive_ls & ~bridge_off;
      slow_slew_q <= oc_off & {NUM_BRIDGES{OVERCURRENT_TURNOFF_SLOW_IN}};
      low_oc_th_q <= LOW_OPENLOAD_THRESHOLD_SELECT_IN;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pullup_q <= FLAGS_RESET;
      pulldown_q <= FLAGS_RESET;
      level_q <= FLAGS_RESET;
    end else begin
      pullup_q <= PULLUP_ENABLE_IN;
      pulldown_q <= PULLDOWN_ENABLE_IN;
      level_q <= sense.level;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alert pin. Thermal terms follow the live sensors so the pin releases on
  // cooling even before software clears the thermal flags.

  assign alert_d = ((|oc_off) & ~OVERCURRENT_ALERT_MASK_IN)
                   | ((|(hs_ol_q | ls_ol_q)) & ~OPENLOAD_ALERT_MASK_IN)
                   | (|sense.sd)
                   | ((|sense.warn) & THERMAL_WARNING_ALERT_ENABLE_IN);

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      alert_oe_n_q <= 1'b1;
    end else begin
      alert_oe_n_q <= ~alert_d;
    end
  end

  assign FAULT_ALERT_N_OUT = 1'b0;
  assign FAULT_ALERT_N_OE_N_OUT = alert_oe_n_q;
  assign FAULT_LINE_LEVEL_OUT = sense.fault_line;
  assign HS_GATE_OUT = hs_gate_q;
  assign LS_GATE_OUT = ls_gate_q;
  assign OC_SLOW_SLEW_OUT = slow_slew_q;
  assign LS_LOW_OC_THRESHOLD_OUT = low_oc_th_q;
  assign PULLUP_OUT = pullup_q;
  assign PULLDOWN_OUT = pulldown_q;
  assign HIGH_SIDE_OVERCURRENT_FLAG_OUT = hs_oc_q;
  assign LOW_SIDE_OVERCURRENT_FLAG_OUT = ls_oc_q;
  assign HS_OPENLOAD_FLAG_OUT = hs_ol_q;
  assign LS_OPENLOAD_FLAG_OUT = ls_ol_q;
  assign OFFSTATE_COMPARE_LEVEL_OUT = level_q;
  assign THERMAL_WARNING_OUT = warn_flag_q;
  assign THERMAL_SHUTDOWN_OUT = sd_flag_q;

  //////////////////////////////////////////////////////////////////////////////
  // Each check watches the bridge that the bench drives into that fault; all bridges share one generate body.

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  sequence ls_trip_s;
    $rose(ls_oc_q[1]) && !$past(hs_oc_conf[1]) && !$past(clear_req);
  endsequence

  sequence oc_latched_s;
    hs_oc_q[0] || ls_oc_q[0];
  endsequence

  a_oc_filtered: assert property ($rose(hs_oc_q[0]) |-> $past(sense.hs_oc[0]) && $past(hs_oc_conf[0]))
    else $error("overcurrent flag set without a filtered condition");
  a_oc_shutdown: assert property (oc_latched_s |=> !HS_GATE_OUT[0] && !LS_GATE_OUT[0])
    else $error("bridge still driven after overcurrent");
  a_oc_side_only: assert property (ls_trip_s |-> hs_oc_q[1] == $past(hs_oc_q[1]))
    else $error("opposite overcurrent flag changed");
  a_oc_alert_low: assert property ((oc_latched_s and !OVERCURRENT_ALERT_MASK_IN) |=> !FAULT_ALERT_N_OE_N_OUT)
    else $error("alert not driven on overcurrent");
  a_oc_hold_off: assert property (ls_oc_q[1] && ls_oc_conf[1] && clear_req |=> ls_oc_q[1])
    else $error("overcurrent flag cleared while condition present");
  a_oc_slew_sel: assert property (oc_latched_s |=> OC_SLOW_SLEW_OUT[0] == $past(OVERCURRENT_TURNOFF_SLOW_IN))
    else $error("overcurrent turn-off slew select wrong");
  a_ol_reaction: assert property (ls_ol_q[2] && !OPENLOAD_FLAG_ONLY_IN |=> !LS_GATE_OUT[2] && !HS_GATE_OUT[2])
    else $error("bridge driven after open load");
  a_ol_blanking: assert property (BRIDGE_PWM_DRIVE_MODE_IN[2] && !PWM_PHASE_ON_IN[2]
    |-> !ls_ol_cond[2] && !hs_ol_cond[2])
    else $error("open-load detection during pwm off phase");
  a_ol_disable: assert property (OPENLOAD_DETECT_DISABLE_IN[2]
    |=> !$rose(hs_ol_conf[2]) && !$rose(ls_ol_conf[2]))
    else $error("open-load detection while disabled");
  a_ol_clear: assert property (ls_ol_q[2] && clear_req && !ls_ol_conf[2] |=> !ls_ol_q[2])
    else $error("open-load flag not cleared");
  a_sd_stage_off: assert property (sense.sd[3]
    |=> THERMAL_SHUTDOWN_OUT[3] && !HS_GATE_OUT[3] && !LS_GATE_OUT[3])
    else $error("stage not off in thermal shutdown");
  a_sd_alert: assert property ((|sense.sd) |=> !FAULT_ALERT_N_OE_N_OUT)
    else $error("alert not driven in thermal shutdown");

endmodule : hb_fault_supervisor

`default_nettype wire

/* File: test/hb_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Host side: owns the stored enables, the drive mode, the PWM generator and the clear command.
module hb_host_model
  import hb_fault_pkg::*;
(
  input wire logic clk_in,
  output logic [NUM_BRIDGES-1:0] hs_en_out,
  output logic [NUM_BRIDGES-1:0] ls_en_out,
  output logic [NUM_BRIDGES-1:0] pwm_mode_out,
  output logic [NUM_BRIDGES-1:0] phase_out,
  output logic clr_out
);
  logic pwm_run;
  logic [3:0] ph_cnt;

  initial begin
    hs_en_out = '0;
    ls_en_out = '0;
    pwm_mode_out = '0;
    clr_out = 1'b0;
    pwm_run = 1'b0;
    ph_cnt = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A stopped generator holds every mapped bridge in its off phase.
  always @(negedge clk_in) begin
    ph_cnt <= ph_cnt + 4'h1;
  end
  assign phase_out = (pwm_run && !ph_cnt[2]) ? pwm_mode_out : '0;

  ////////////////////////////////////////////////////////////////////////////
  task automatic pulse_clear();
    @(negedge clk_in) clr_out = 1'b1;
    @(negedge clk_in) clr_out = 1'b0;
  endtask : pulse_clear

  task automatic set_side(input int b, input logic hs, input logic on);
    @(negedge clk_in);
    if (hs) hs_en_out[b] = on;
    else ls_en_out[b] = on;
  endtask : set_side

  // The generator restarts only after all settings, so paralleled switches start together.
  task automatic setup_pwm(input int b, input logic hs, input logic run);
    @(negedge clk_in) pwm_run = 1'b0;
    pwm_mode_out[b] = 1'b1;
    set_side(b, hs, 1'b1);
    @(negedge clk_in) pwm_run = run;
  endtask : setup_pwm

  // Paralleled on/off bridges come from one enable group, so a single write switches them together.
  task automatic set_group(input int b0, input int b1, input logic on);
    @(negedge clk_in);
    if (b0 / 4 == b1 / 4) begin
      ls_en_out[b0] = on;
      ls_en_out[b1] = on;
    end
  endtask : set_group

  task automatic recover(input int b, input logic hs);
    set_side(b, hs, 1'b0);
    pulse_clear();
    set_side(b, hs, 1'b1);
  endtask : recover
endmodule : hb_host_model

`default_nettype wire

/* File: test/hb_fault_supervisor_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module hb_fault_supervisor_tb_top;
  import hb_fault_pkg::*;
  logic clk, rst, clr, oc_mask, rc_en, st_rd, slow, flt_sel, ol_only, ol_mask, tw_en, alert_wire;
  logic alert_d, oe_n, line_lvl, tw_flag;
  logic [NUM_BRIDGES-1:0] hs_en, ls_en, pwm_mode, phase, ol_low, ol_dis, pu_en, pd_en, hs_oc, ls_oc;
  logic [NUM_BRIDGES-1:0] hs_ul, ls_ul, ls_ul_low, cmp, t_warn, t_sd, hs_g, ls_g, slew, low_oc, pu, pd;
  logic [NUM_BRIDGES-1:0] hs_ocf, ls_ocf, hs_olf, ls_olf, lvl, t_sdf;
  int error_cnt = 0;
  int n_compared = 0;

  hb_host_model host (.clk_in(clk), .hs_en_out(hs_en), .ls_en_out(ls_en), .pwm_mode_out(pwm_mode),
    .phase_out(phase), .clr_out(clr));

  hb_fault_supervisor #(.OL_CYCLES(20'h00014), .OL_LOW_CYCLES(20'h0000A), .OC_LONG_NS(200),
    .OC_SHORT_NS(100)) uut (
    .MCLK_IN(clk), .RST_IN(rst), .HIGH_SIDE_ENABLE_IN(hs_en), .LOW_SIDE_ENABLE_IN(ls_en),
    .BRIDGE_PWM_DRIVE_MODE_IN(pwm_mode), .PWM_PHASE_ON_IN(phase), .OVERCURRENT_ALERT_MASK_IN(oc_mask),
    .READ_CLEARS_FLAGS_IN(rc_en), .STATUS_READ_IN(st_rd), .CLEAR_FAULT_COMMAND_IN(clr),
    .OVERCURRENT_TURNOFF_SLOW_IN(slow), .OVERCURRENT_FILTER_SELECT_IN(flt_sel),
    .LOW_OPENLOAD_THRESHOLD_SELECT_IN(ol_low), .OPENLOAD_FLAG_ONLY_IN(ol_only),
    .OPENLOAD_ALERT_MASK_IN(ol_mask), .OPENLOAD_DETECT_DISABLE_IN(ol_dis),
    .THERMAL_WARNING_ALERT_ENABLE_IN(tw_en), .PULLUP_ENABLE_IN(pu_en), .PULLDOWN_ENABLE_IN(pd_en),
    .HS_OVERCURRENT_IN(hs_oc), .LS_OVERCURRENT_IN(ls_oc), .HS_UNDERLOAD_IN(hs_ul),
    .LS_UNDERLOAD_IN(ls_ul), .LS_UNDERLOAD_LOW_IN(ls_ul_low), .OFFSTATE_COMPARE_IN(cmp),
    .THERMAL_WARNING_IN(t_warn), .THERMAL_SHUTDOWN_IN(t_sd), .FAULT_ALERT_N_IN(alert_wire),
    .FAULT_ALERT_N_OUT(alert_d), .FAULT_ALERT_N_OE_N_OUT(oe_n), .FAULT_LINE_LEVEL_OUT(line_lvl),
    .HS_GATE_OUT(hs_g), .LS_GATE_OUT(ls_g), .OC_SLOW_SLEW_OUT(slew), .LS_LOW_OC_THRESHOLD_OUT(low_oc),
    .PULLUP_OUT(pu), .PULLDOWN_OUT(pd), .HIGH_SIDE_OVERCURRENT_FLAG_OUT(hs_ocf),
    .LOW_SIDE_OVERCURRENT_FLAG_OUT(ls_ocf), .HS_OPENLOAD_FLAG_OUT(hs_olf), .LS_OPENLOAD_FLAG_OUT(ls_olf),
    .OFFSTATE_COMPARE_LEVEL_OUT(lvl), .THERMAL_WARNING_OUT(tw_flag), .THERMAL_SHUTDOWN_OUT(t_sdf));

  // The alert wire has an external pull-up, so a released driver reads high.
  assign alert_wire = oe_n ? 1'b1 : alert_d;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic read_pulse();
    st_rd = 1'b1;
    wait_n(1);
    st_rd = 1'b0;
  endtask : read_pulse

  ////////////////////////////////////////////////////////////////////////////
  // A glitch shorter than the long filter passes; the short filter confirms the same glitch.
  task automatic t_overcurrent_filter_select();
    host.set_side(0, 1'b1, 1'b1);
    flt_sel = 1'b0;
    hs_oc[0] = 1'b1;
    wait_n(15);
    hs_oc[0] = 1'b0;
    wait_n(10);
    check(hs_ocf, 16'h0000);
    check(hs_g[0], 16'h0001);
    flt_sel = 1'b1;
    hs_oc[0] = 1'b1;
    wait_n(15);
    hs_oc[0] = 1'b0;
    wait_n(10);
    check(hs_ocf, 16'h0001);
    check(ls_ocf, 16'h0000);
    check({hs_g[0], ls_g[0]}, 16'h0000);
    check({alert_d, oe_n, line_lvl}, 16'h0000);
    check(slew[0], 16'h0000);
    host.recover(0, 1'b1);
    wait_n(3);
    check({hs_ocf[0], hs_g[0], oe_n}, 16'h0003);
  endtask : t_overcurrent_filter_select

  // Masked, slow turn-off; a read-clear while the fault persists is lost.
  task automatic t_oc_hold();
    host.set_side(1, 1'b0, 1'b1);
    {oc_mask, slow, rc_en} = 3'h7;
    ls_oc[1] = 1'b1;
    wait_n(30);
    check(ls_ocf, 16'h0002);
    check(hs_ocf, 16'h0000);
    check({ls_g[1], oe_n, slew[1]}, 16'h0003);
    read_pulse();
    wait_n(3);
    check({ls_ocf[1], ls_g[1]}, 16'h0002);
    ls_oc[1] = 1'b0;
    wait_n(8);
    read_pulse();
    wait_n(3);
    check({ls_ocf[1], ls_g[1]}, 16'h0001);
    {oc_mask, slow} = 2'h0;
  endtask : t_oc_hold

  // Open load on the low side of bridge 2 over a table of reactions.
  task automatic t_openload();
    logic [4:0] cfg [5] = '{5'h00, 5'h18, 5'h1C, 5'h1A, 5'h01};
    logic [2:0] res [5] = '{3'h4, 3'h7, 3'h3, 3'h7, 3'h1};
    for (int i = 0; i < 5; i++) begin
      {ol_only, ol_mask, ol_dis[2], ol_low[2]} = cfg[i][4:1];
      if (cfg[i][0]) host.setup_pwm(2, 1'b0, 1'b0);
      else host.set_side(2, 1'b0, 1'b1);
      ls_ul[2] = !ol_low[2];
      ls_ul_low[2] = ol_low[2];
      wait_n(40);
      check(ls_olf[2], res[i][2]);
      check(ls_g[2], res[i][1]);
      check(oe_n, res[i][0]);
      check(low_oc[2], ol_low[2]);
      {ls_ul[2], ls_ul_low[2]} = 2'h0;
      host.set_side(2, 1'b0, 1'b0);
      host.pulse_clear();
      wait_n(4);
      check(ls_olf[2], 16'h0000);
    end
  endtask : t_openload

  task automatic t_thermal();
    host.set_side(3, 1'b1, 1'b1);
    t_warn[3] = 1'b1;
    wait_n(8);
    check({tw_flag, hs_g[3], oe_n}, 16'h0007);
    tw_en = 1'b1;
    wait_n(3);
    check(oe_n, 16'h0000);
    {t_warn[3], tw_en, t_sd[3]} = 3'h1;
    wait_n(8);
    check(t_sdf, 16'h0008);
    check({hs_g[3], oe_n}, 16'h0000);
    t_sd[3] = 1'b0;
    wait_n(8);
    check({t_sdf, tw_flag, hs_g[3], oe_n}, 16'h0047);
    host.pulse_clear();
    wait_n(3);
    check({t_sdf, tw_flag}, 16'h0000);
  endtask : t_thermal

  task automatic t_offstate();
    {pu_en, pd_en, cmp} = {12'hA5A, 12'h5A5, 12'h3C3};
    wait_n(6);
    check({pu, pd}, {12'hA5A, 12'h5A5});
    check(lvl, 16'h03C3);
    cmp = 12'hC3C;
    wait_n(6);
    check(lvl, 16'h0C3C);
    host.set_group(4, 5, 1'b1);
    wait_n(1);
    check(ls_g[5:4], 16'h0003);
    host.set_group(4, 5, 1'b0);
    wait_n(1);
    check(ls_g[5:4], 16'h0000);
    hs_ul[0] = 1'b1;
    wait_n(30);
    check({hs_olf[0], hs_g[0], oe_n}, 16'h0004);
    hs_ul[0] = 1'b0;
    host.pulse_clear();
    wait_n(3);
    check({hs_olf[0], hs_g[0], oe_n}, 16'h0003);
  endtask : t_offstate

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200us;
    error_cnt++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    {st_rd, oc_mask, rc_en, slow, flt_sel, ol_only, ol_mask, tw_en} = 8'h00;
    {ol_low, ol_dis, pu_en, pd_en, hs_oc, ls_oc} = '0;
    {hs_ul, ls_ul, ls_ul_low, cmp, t_warn, t_sd} = '0;
    wait_n(10);
    rst = 1'b0;
    wait_n(5);
    check({hs_g, ls_g, oe_n}, 16'h0001);
    check({hs_ocf, ls_ocf, t_sdf, tw_flag}, 16'h0000);
    t_overcurrent_filter_select();
    t_oc_hold();
    t_openload();
    t_thermal();
    t_offstate();
    conclude();
  end
endmodule : hb_fault_supervisor_tb_top

`default_nettype wire
